// ===== ccpo_pkg.sv
// Purpose: shared types and constants for the channel coarse phase offset block
// Assumes: one sample clock feeds both channels
// Notes:   offsets are counted in waveform points

package ccpo_pkg;

    // ==========================================================
    // widths and constants
    localparam int unsigned CCPO_PT_W      = 24;
    localparam logic [CCPO_PT_W-1:0] CCPO_OFS_RST = 24'h000000;
    localparam int unsigned CCPO_STEP_LOG2 = 3;
    localparam logic [CCPO_PT_W-1:0] CCPO_STEP    = 24'h000008;
    localparam logic [CCPO_PT_W-1:0] CCPO_MARGIN  = 24'h000080;

    typedef enum logic [1:0] {
        CCPO_RUN_CONT,
        CCPO_RUN_TRIG,
        CCPO_RUN_GATED,
        CCPO_RUN_BURST
    } ccpo_run_t;

    // host command: write or query one channel's offset
    typedef struct packed {
        logic                 wr;
        logic                 rd;
        logic                 ch;
        logic [CCPO_PT_W-1:0] value;
    } ccpo_cmd_t;

    // query answer
    typedef struct packed {
        logic                 valid;
        logic [CCPO_PT_W-1:0] value;
    } ccpo_rsp_t;

endpackage

// ===== ccpo_core.sv
// Purpose: coarse start-phase offset between two coupled output channels
// Assumes: host keeps values in 0..len-128 and equal lengths on both channels
// Notes:   delay is quantised to 8 sample clocks
// Operation
// - the lag between channels is the difference of the two settings.
// - the offset is applied only in steps of eight sample clocks.
// - the offset acts only in continuous run mode with the channels synchronised.
// - a query returns the held offset in waveform points.
// - the offset is honoured only while coupled; either channel may lead.

`timescale 1ns/1ps

module ccpo_core
    import ccpo_pkg::*;
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst_b,
    input  wire logic      clk_en,
    // host command and answer
    input  wire ccpo_cmd_t cmd,
    output ccpo_rsp_t      rsp,
    // mode from the rest of the generator
    input  wire ccpo_run_t run_mode,
    input  wire logic      couple_on,
    // start request and per-channel starts
    input  wire logic      start_req,
    output logic           start_ch1,
    output logic           start_ch2,
    output logic           delay_busy
);

    // ==========================================================
    // offset settings
    logic [CCPO_PT_W-1:0] ofs1_reg, ofs2_reg;
    logic                 apply;
    logic [CCPO_PT_W-1:0] diff;
    logic                 ch2_lags;
    logic [CCPO_PT_W-1:0] dly_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ofs1_reg <= CCPO_OFS_RST;
            ofs2_reg <= CCPO_OFS_RST;
        end else if (clk_en && cmd.wr) begin
            if (cmd.ch)
                ofs2_reg <= cmd.value;
            else
                ofs1_reg <= cmd.value;
        end
    end

    // query answer, one cycle after the request
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rsp <= '0;
        end else if (clk_en) begin
            rsp.valid <= cmd.rd;
            rsp.value <= cmd.ch ? ofs2_reg : ofs1_reg;
        end
    end

    // ==========================================================
    // relative delay
    assign apply    = couple_on && (run_mode == CCPO_RUN_CONT);
    assign ch2_lags = (ofs1_reg >= ofs2_reg);
    assign diff     = ch2_lags ? (ofs1_reg - ofs2_reg) : (ofs2_reg - ofs1_reg);
    // drop the low bits: finer phase belongs to the skew stage
    assign dly_q    = {diff[CCPO_PT_W-1:CCPO_STEP_LOG2], {CCPO_STEP_LOG2{1'b0}}};

    // ==========================================================
    // start sequencing
    logic [CCPO_PT_W-1:0] cnt_reg;
    logic                 lag2_reg;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_reg    <= '0;
            lag2_reg   <= 1'b0;
            delay_busy <= 1'b0;
            start_ch1  <= 1'b0;
            start_ch2  <= 1'b0;
        end else if (clk_en) begin
            start_ch1 <= 1'b0;
            start_ch2 <= 1'b0;
            if (start_req && !delay_busy) begin
                if (!apply || dly_q == '0) begin
                    start_ch1 <= 1'b1;
                    start_ch2 <= 1'b1;
                end else begin
                    // leading channel starts now, the other waits
                    start_ch1  <= ch2_lags;
                    start_ch2  <= !ch2_lags;
                    lag2_reg   <= ch2_lags;
                    cnt_reg    <= dly_q - 24'h000001;
                    delay_busy <= 1'b1;
                end
            end else if (delay_busy) begin
                if (cnt_reg == '0) begin
                    delay_busy <= 1'b0;
                    start_ch2  <= lag2_reg;
                    start_ch1  <= !lag2_reg;
                end else begin
                    cnt_reg <= cnt_reg - 24'h000001;
                end
            end
        end
    end

    // ==========================================================
    // checks
    a_uncoupled_together: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && start_req && !delay_busy && !apply |=> start_ch1 && start_ch2)
        else $error("uncoupled start not simultaneous");

    a_query_value: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && cmd.rd && !cmd.ch |=> rsp.valid && rsp.value == $past(ofs1_reg))
        else $error("query value wrong");

    a_step_eight: assert property (@(posedge clk) disable iff (!rst_b)
        dly_q[CCPO_STEP_LOG2-1:0] == '0)
        else $error("delay not multiple of eight");

    a_lag_diff: assert property (@(posedge clk) disable iff (!rst_b)
        ofs1_reg >= ofs2_reg |-> dly_q == ((ofs1_reg - ofs2_reg) & ~(CCPO_STEP - 24'h000001)))
        else $error("lag not difference of settings");

    a_gate_mode: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && start_req && !delay_busy && dly_q != '0 && apply |=> delay_busy)
        else $error("coupled offset not applied");

    a_busy_count: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && delay_busy && cnt_reg == '0 |=> !delay_busy && (start_ch1 || start_ch2))
        else $error("delayed start missing");

    // ==========================================================
    // lag measurement: cycles from the leading to the lagging start
    // kept apart from cnt_reg so the check does not reuse the counter it judges
    logic [CCPO_PT_W-1:0] lag_cnt_reg;
    logic [CCPO_PT_W-1:0] lag_exp_reg;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lag_cnt_reg <= '0;
            lag_exp_reg <= '0;
        end else if (clk_en) begin
            if (start_req && !delay_busy) begin
                lag_cnt_reg <= '0;
                lag_exp_reg <= dly_q;
            end else if (delay_busy) begin
                lag_cnt_reg <= lag_cnt_reg + 24'h000001;
            end
        end
    end

    // ==========================================================
    // start sequences
    sequence s_lead_start;
        clk_en && start_req && !delay_busy && apply && dly_q != '0;
    endsequence

    sequence s_lag_done;
        clk_en && delay_busy && cnt_reg == '0;
    endsequence

    sequence s_lag_wait;
        clk_en && delay_busy && cnt_reg != '0;
    endsequence

    // ==========================================================
    // sequencing checks
    a_lead_first: assert property (@(posedge clk) disable iff (!rst_b)
        s_lead_start |=> delay_busy && (start_ch1 == $past(ch2_lags)) && (start_ch2 == !$past(ch2_lags)))
        else $error("wrong leading channel");

    a_load_count: assert property (@(posedge clk) disable iff (!rst_b)
        s_lead_start |=> cnt_reg == $past(dly_q) - 24'h000001)
        else $error("delay counter load wrong");

    a_lag_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        s_lag_done |=> (start_ch2 == $past(lag2_reg)) && (start_ch1 == !$past(lag2_reg)))
        else $error("lagging start on wrong channel");

    a_lag_length: assert property (@(posedge clk) disable iff (!rst_b)
        s_lag_done |=> lag_cnt_reg == lag_exp_reg)
        else $error("lag length not the quantised difference");

    a_refuse_busy: assert property (@(posedge clk) disable iff (!rst_b)
        s_lag_wait |=> delay_busy && !start_ch1 && !start_ch2)
        else $error("start while delay pending");

    a_count_down: assert property (@(posedge clk) disable iff (!rst_b)
        s_lag_wait |=> cnt_reg == $past(cnt_reg) - 24'h000001)
        else $error("delay counter not counting down");

    // ==========================================================
    // setting and query checks
    a_write_ch1: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && cmd.wr && !cmd.ch |=> ofs1_reg == $past(cmd.value))
        else $error("channel 1 write lost");

    a_write_ch2: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && cmd.wr && cmd.ch |=> ofs2_reg == $past(cmd.value))
        else $error("channel 2 write lost");

    a_query_ch2: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && cmd.rd && cmd.ch |=> rsp.valid && rsp.value == $past(ofs2_reg))
        else $error("channel 2 query value wrong");

    a_freeze_state: assert property (@(posedge clk) disable iff (!rst_b)
        !clk_en |=> $stable(ofs1_reg) && $stable(ofs2_reg) && $stable(cnt_reg) && $stable(delay_busy))
        else $error("state moved while clock enable low");

    // reset itself is the antecedent here, so no disable clause
    a_reset_zero: assert property (@(posedge clk)
        !rst_b |=> ofs1_reg == CCPO_OFS_RST && ofs2_reg == CCPO_OFS_RST && !delay_busy)
        else $error("reset values wrong");

endmodule // ccpo_core

// ===== ccpo_core_tb_top.sv
// Purpose: self-checking bench for the channel coarse phase offset block
// Assumes: all inputs change on the falling clock edge
// Notes:   lag is measured as the cycle distance between the two start pulses
`timescale 1ns/1ps

module ccpo_core_tb_top;
    import ccpo_pkg::*;
    // ==========================================================
    // stimulus and observation
    logic      clk, rst_b, clk_en, couple_on, start_req;
    logic      start_ch1, start_ch2, delay_busy;
    ccpo_cmd_t cmd;
    ccpo_rsp_t rsp;
    ccpo_run_t run_mode;
    int        mismatches, n_tests;

    ccpo_core dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .cmd(cmd), .rsp(rsp), .run_mode(run_mode),
        .couple_on(couple_on), .start_req(start_req), .start_ch1(start_ch1), .start_ch2(start_ch2),
        .delay_busy(delay_busy));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ==========================================================
    // shared tasks
    task automatic complete_run;
        $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_ofs(input logic ch, input logic [23:0] v);
        cmd = '{1'b1, 1'b0, ch, v};
        @(negedge clk);
        cmd = '0;
        @(negedge clk);
    endtask

    task automatic rd_ofs(input logic ch, input logic [23:0] exp);
        cmd = '{1'b0, 1'b1, ch, 24'h000000};
        @(negedge clk);
        cmd = '0;
        chk({23'h000000, rsp.valid}, 24'h000001);
        chk(rsp.value, exp);
        @(negedge clk);
    endtask

    // exp_d is ch2 start minus ch1 start, modulo 2^24
    task automatic run_start(input logic [23:0] exp_d);
        logic [23:0] t1, t2;
        t1 = '1;
        t2 = '1;
        start_req = 1'b1;
        @(negedge clk);
        start_req = 1'b0;
        for (int i = 0; i < 3000 && (t1 === '1 || t2 === '1 || delay_busy !== 1'b0); i++) begin
            if (start_ch1 === 1'b1) t1 = i[23:0];
            if (start_ch2 === 1'b1) t2 = i[23:0];
            @(negedge clk);
        end
        if (t1 === '1 || t2 === '1) begin
            mismatches++;
            complete_run;
        end else chk(t2 - t1, exp_d);
    endtask

    // ==========================================================
    // scenarios
    task automatic sc_reset;
        rd_ofs(1'b0, 24'h000000);
        rd_ofs(1'b1, 24'h000000);
        run_start(24'h000000);
    endtask

    task automatic sc_lag;
        wr_ofs(1'b1, 24'h000400);
        wr_ofs(1'b0, 24'h000800);
        rd_ofs(1'b0, 24'h000800);
        run_start(24'h000400);
    endtask

    task automatic sc_round;
        wr_ofs(1'b0, 24'h000000);
        wr_ofs(1'b1, 24'h00000d);
        rd_ofs(1'b1, 24'h00000d);
        run_start(24'hfffff8);
    endtask

    task automatic sc_modes;
        for (int m = 1; m < 4; m++) begin
            run_mode = ccpo_run_t'(m);
            run_start(24'h000000);
        end
        run_mode = CCPO_RUN_CONT;
        couple_on = 1'b0;
        run_start(24'h000000);
        couple_on = 1'b1;
        run_start(24'hfffff8);
    endtask

    // a second request while the lag is pending must be ignored
    task automatic sc_refuse;
        wr_ofs(1'b0, 24'h000010);
        wr_ofs(1'b1, 24'h000000);
        start_req = 1'b1;
        @(negedge clk);
        chk({22'h000000, start_ch1, delay_busy}, 24'h000003);
        @(negedge clk);
        start_req = 1'b0;
        chk({22'h000000, start_ch1, start_ch2}, 24'h000000);
        repeat (15) @(negedge clk);
        chk({22'h000000, start_ch2, delay_busy}, 24'h000002);
    endtask

    // a write with the clock enable low must not land
    task automatic sc_freeze;
        clk_en = 1'b0;
        wr_ofs(1'b0, 24'h000100);
        clk_en = 1'b1;
        rd_ofs(1'b0, 24'h000010);
    endtask

    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        cmd = '0;
        run_mode = CCPO_RUN_CONT;
        couple_on = 1'b1;
        start_req = 1'b0;
        mismatches = 0;
        n_tests = 0;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        sc_reset;
        sc_lag;
        sc_round;
        sc_modes;
        sc_refuse;
        sc_freeze;
        complete_run;
    end
endmodule // ccpo_core_tb_top
